/* rtl/ccl_consts.vh */
/*
 comparator control constants: register addresses, pages, bit positions,
 reset values. assumes inclusion by bare name from the design files.
*/
`ifndef CCL_CONSTS_VH
`define CCL_CONSTS_VH

`define CCL_ADDR_CTRL 8'h88
`define CCL_ADDR_MODE 8'h89
`define CCL_PAGE_CMP0 8'h01
`define CCL_PAGE_CMP1 8'h02
`define CCL_PAGE_CMP2 8'h03

`define CCL_CTRL_ON_BIT 7
`define CCL_CTRL_LEVEL_BIT 6
`define CCL_CTRL_RISE_BIT 5
`define CCL_CTRL_FALL_BIT 4
`define CCL_CTRL_PHYS_HI 3
`define CCL_CTRL_PHYS_LO 2
`define CCL_CTRL_NHYS_HI 1
`define CCL_CTRL_NHYS_LO 0

`define CCL_MODE_RIE_BIT 5
`define CCL_MODE_FIE_BIT 4
`define CCL_MODE_RESP_HI 1
`define CCL_MODE_RESP_LO 0

`define CCL_CTRL_RESET 8'h00
`define CCL_MODE_RESET 8'h02
`define CCL_RESP_RESET 2'h2
`define CCL_CTRL_WMASK 8'hbf
`define CCL_MODE_WMASK 8'h33

`define CCL_POWERUP_NS 10000
`define CCL_CLK_PERIOD_NS 5

`endif

/* rtl/ccl_sync.v */
/*
 two-flop synchroniser for a vector of asynchronous levels.
 assumes the inputs come from outside the clock domain.
*/
`timescale 1ns/1ps
`default_nettype none

module ccl_sync #(
    parameter WIDTH = 3
) (
    input wire clk_in,
    input wire reset_in,
    input wire [WIDTH-1:0] async_in,
    output wire [WIDTH-1:0] sync_out
);
    reg [WIDTH-1:0] meta_ff;
    reg [WIDTH-1:0] stable_ff;

    always @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            meta_ff <= {WIDTH{1'b0}};
            stable_ff <= {WIDTH{1'b0}};
        end else begin
            meta_ff <= async_in;
            stable_ff <= meta_ff;
        end
    end

    assign sync_out = stable_ff;
endmodule

`default_nettype wire

/* rtl/ccl_comparator_ctrl.v */
/*
 control and status logic for three voltage comparators, reached through
 paged special-function registers at two shared addresses.
 assumes a single-cycle register port on the system clock; the analog
 cores sit outside and deliver asynchronous output levels.
*/
`timescale 1ns/1ps
`default_nettype none
`include "ccl_consts.vh"

module ccl_comparator_ctrl #(
    parameter NUM_CMP = 3
) (
    // clock and reset
    input wire CLK_IN,
    input wire RESET_IN,
    // register port
    input wire [7:0] REG_ADDR_IN,
    input wire [7:0] REG_PAGE_IN,
    input wire REG_WR_IN,
    input wire REG_RD_IN,
    input wire [7:0] REG_WDATA_IN,
    output reg [7:0] REG_RDATA_OUT,
    output reg REG_HIT_OUT,
    // interrupt controller
    input wire [NUM_CMP-1:0] EXT_IRQ_EN_IN,
    output reg [NUM_CMP-1:0] IRQ_REQ_OUT,
    // analog cores
    input wire [NUM_CMP-1:0] CMP_RAW_IN,
    output reg [NUM_CMP-1:0] CMP_ON_OUT,
    output reg [2*NUM_CMP-1:0] POS_HYST_SEL_OUT,
    output reg [2*NUM_CMP-1:0] NEG_HYST_SEL_OUT,
    output reg [2*NUM_CMP-1:0] RESPONSE_MODE_SEL_OUT,
    // output routing
    output reg [NUM_CMP-1:0] CMP_LEVEL_OUT,
    output reg [NUM_CMP-1:0] CMP_PIN_OUT,
    output reg [NUM_CMP-1:0] CMP_RESET_SRC_OUT,
    // power-up settled, informational
    output reg [NUM_CMP-1:0] CMP_READY_OUT
);
    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam POWERUP_NS = `CCL_POWERUP_NS;
    localparam POWERUP_CYC = (POWERUP_NS + `CCL_CLK_PERIOD_NS - 1) / `CCL_CLK_PERIOD_NS;
    localparam [11:0] POWERUP_MAX = POWERUP_CYC[11:0] - 12'h001;

    // page decode, shared by read and write paths
    function [1:0] page_to_idx;
        input [7:0] page;
        begin
            case (page)
                `CCL_PAGE_CMP0: page_to_idx = 2'h0;
                `CCL_PAGE_CMP1: page_to_idx = 2'h1;
                `CCL_PAGE_CMP2: page_to_idx = 2'h2;
                default: page_to_idx = 2'h3;
            endcase
        end
    endfunction

    // ------------------------------------------------------------
    // synchronise
    // ------------------------------------------------------------
    wire [NUM_CMP-1:0] level_sync;

    ccl_sync #(.WIDTH(NUM_CMP)) u_sync (
        .clk_in(CLK_IN),
        .reset_in(RESET_IN),
        .async_in(CMP_RAW_IN),
        .sync_out(level_sync)
    );

    // ------------------------------------------------------------
    // register decode
    // ------------------------------------------------------------
    wire [1:0] sel_idx = page_to_idx(REG_PAGE_IN);
    wire page_ok = (sel_idx != 2'h3);
    wire hit_ctrl = page_ok && (REG_ADDR_IN == `CCL_ADDR_CTRL);
    wire hit_mode = page_ok && (REG_ADDR_IN == `CCL_ADDR_MODE);

    // one slice per comparator, so every register keeps a single driver
    wire [8*NUM_CMP-1:0] ctrl_all;
    wire [8*NUM_CMP-1:0] mode_all;
    wire [NUM_CMP-1:0] nxt_irq;
    wire [NUM_CMP-1:0] nxt_on;
    wire [2*NUM_CMP-1:0] nxt_phys;
    wire [2*NUM_CMP-1:0] nxt_nhys;
    wire [2*NUM_CMP-1:0] nxt_resp;
    wire [NUM_CMP-1:0] nxt_pin;
    wire [NUM_CMP-1:0] nxt_ready;

    // ------------------------------------------------------------
    // per-comparator state
    // ------------------------------------------------------------
    genvar g;
    generate
        for (g = 0; g < NUM_CMP; g = g + 1) begin : g_cmp
            reg [7:0] ctrl_ff;
            reg [7:0] mode_ff;
            reg prev_ff;
            reg [11:0] pwr_cnt_ff;
            reg [7:0] nxt_ctrl;
            reg [7:0] nxt_mode;
            wire wr_c = REG_WR_IN && hit_ctrl && (sel_idx == g);
            wire wr_m = REG_WR_IN && hit_mode && (sel_idx == g);
            // edges count only while on, so a powered-down core cannot raise flags
            wire rise = ctrl_ff[`CCL_CTRL_ON_BIT] && level_sync[g] && !prev_ff;
            wire fall = ctrl_ff[`CCL_CTRL_ON_BIT] && !level_sync[g] && prev_ff;

            always @* begin
                nxt_ctrl = ctrl_ff;
                if (wr_c) begin
                    nxt_ctrl = REG_WDATA_IN & `CCL_CTRL_WMASK;
                end
                // set beats a simultaneous software clear
                if (rise) begin
                    nxt_ctrl[`CCL_CTRL_RISE_BIT] = 1'b1;
                end
                if (fall) begin
                    nxt_ctrl[`CCL_CTRL_FALL_BIT] = 1'b1;
                end
                nxt_ctrl[`CCL_CTRL_LEVEL_BIT] = 1'b0;
            end

            always @* begin
                nxt_mode = mode_ff;
                if (wr_m) begin
                    nxt_mode = REG_WDATA_IN & `CCL_MODE_WMASK;
                end
            end

            always @(posedge CLK_IN or posedge RESET_IN) begin
                if (RESET_IN) begin
                    ctrl_ff <= `CCL_CTRL_RESET;
                    mode_ff <= `CCL_MODE_RESET;
                    prev_ff <= 1'b0;
                    pwr_cnt_ff <= 12'h000;
                end else begin
                    ctrl_ff <= nxt_ctrl;
                    mode_ff <= nxt_mode;
                    prev_ff <= level_sync[g];
                    // settling is software's duty; this only reports elapsed time
                    if (!ctrl_ff[`CCL_CTRL_ON_BIT]) begin
                        pwr_cnt_ff <= 12'h000;
                    end else if (pwr_cnt_ff != POWERUP_MAX) begin
                        pwr_cnt_ff <= pwr_cnt_ff + 12'h001;
                    end
                end
            end

            assign ctrl_all[8*g+7:8*g] = ctrl_ff;
            assign mode_all[8*g+7:8*g] = mode_ff;
            // request level follows the enabled, gated sticky flags
            assign nxt_irq[g] = EXT_IRQ_EN_IN[g] && (
                (nxt_ctrl[`CCL_CTRL_RISE_BIT] && mode_ff[`CCL_MODE_RIE_BIT]) ||
                (nxt_ctrl[`CCL_CTRL_FALL_BIT] && mode_ff[`CCL_MODE_FIE_BIT]));
            assign nxt_on[g] = nxt_ctrl[`CCL_CTRL_ON_BIT];
            assign nxt_phys[2*g+1:2*g] = nxt_ctrl[`CCL_CTRL_PHYS_HI:`CCL_CTRL_PHYS_LO];
            assign nxt_nhys[2*g+1:2*g] = nxt_ctrl[`CCL_CTRL_NHYS_HI:`CCL_CTRL_NHYS_LO];
            assign nxt_resp[2*g+1:2*g] = nxt_mode[`CCL_MODE_RESP_HI:`CCL_MODE_RESP_LO];
            // pin forced low while shut down
            assign nxt_pin[g] = ctrl_ff[`CCL_CTRL_ON_BIT] && level_sync[g];
            assign nxt_ready[g] = ctrl_ff[`CCL_CTRL_ON_BIT] &&
                (pwr_cnt_ff == POWERUP_MAX);
        end
    endgenerate

    // ------------------------------------------------------------
    // output registers
    // ------------------------------------------------------------
    always @(posedge CLK_IN or posedge RESET_IN) begin
        if (RESET_IN) begin
            IRQ_REQ_OUT <= {NUM_CMP{1'b0}};
            CMP_ON_OUT <= {NUM_CMP{1'b0}};
            POS_HYST_SEL_OUT <= {2*NUM_CMP{1'b0}};
            NEG_HYST_SEL_OUT <= {2*NUM_CMP{1'b0}};
            RESPONSE_MODE_SEL_OUT <= {NUM_CMP{`CCL_RESP_RESET}};
            CMP_LEVEL_OUT <= {NUM_CMP{1'b0}};
            CMP_PIN_OUT <= {NUM_CMP{1'b0}};
            CMP_RESET_SRC_OUT <= {NUM_CMP{1'b0}};
            CMP_READY_OUT <= {NUM_CMP{1'b0}};
        end else begin
            IRQ_REQ_OUT <= nxt_irq;
            CMP_ON_OUT <= nxt_on;
            POS_HYST_SEL_OUT <= nxt_phys;
            NEG_HYST_SEL_OUT <= nxt_nhys;
            RESPONSE_MODE_SEL_OUT <= nxt_resp;
            CMP_LEVEL_OUT <= level_sync;
            CMP_PIN_OUT <= nxt_pin;
            CMP_RESET_SRC_OUT <= nxt_pin;
            CMP_READY_OUT <= nxt_ready;
        end
    end

    // ------------------------------------------------------------
    // read path
    // ------------------------------------------------------------
    // a loop over slices keeps an unmapped page from indexing past the end
    integer i;
    reg [7:0] nxt_rdata;
    always @* begin
        nxt_rdata = 8'h00;
        for (i = 0; i < NUM_CMP; i = i + 1) begin
            if (hit_ctrl && (sel_idx == i)) begin
                nxt_rdata = ctrl_all[8*i +: 8];
                nxt_rdata[`CCL_CTRL_LEVEL_BIT] = level_sync[i];
            end else if (hit_mode && (sel_idx == i)) begin
                nxt_rdata = mode_all[8*i +: 8];
            end
        end
    end

    always @(posedge CLK_IN or posedge RESET_IN) begin
        if (RESET_IN) begin
            REG_RDATA_OUT <= 8'h00;
            REG_HIT_OUT <= 1'b0;
        end else begin
            REG_RDATA_OUT <= REG_RD_IN ? nxt_rdata : 8'h00;
            REG_HIT_OUT <= (REG_RD_IN || REG_WR_IN) && (hit_ctrl || hit_mode);
        end
    end
endmodule

`default_nettype wire

/* test/ccl_chk.sv */
/* assertions on the comparator control ports.
 assumes a bind onto the top module, one clock domain. */
`timescale 1ns/1ps
`default_nettype none
module ccl_chk #(
    parameter NUM_CMP = 3
) (
    input wire CLK_IN,
    input wire RESET_IN,
    input wire [7:0] REG_ADDR_IN,
    input wire [7:0] REG_PAGE_IN,
    input wire REG_WR_IN,
    input wire REG_RD_IN,
    input wire [7:0] REG_WDATA_IN,
    input wire [7:0] REG_RDATA_OUT,
    input wire REG_HIT_OUT,
    input wire [NUM_CMP-1:0] EXT_IRQ_EN_IN,
    input wire [NUM_CMP-1:0] IRQ_REQ_OUT,
    input wire [NUM_CMP-1:0] CMP_RAW_IN,
    input wire [NUM_CMP-1:0] CMP_ON_OUT,
    input wire [2*NUM_CMP-1:0] POS_HYST_SEL_OUT,
    input wire [2*NUM_CMP-1:0] NEG_HYST_SEL_OUT,
    input wire [2*NUM_CMP-1:0] RESPONSE_MODE_SEL_OUT,
    input wire [NUM_CMP-1:0] CMP_LEVEL_OUT,
    input wire [NUM_CMP-1:0] CMP_PIN_OUT,
    input wire [NUM_CMP-1:0] CMP_RESET_SRC_OUT,
    input wire [NUM_CMP-1:0] CMP_READY_OUT
);
    // edges since reset; the sync chain is not trusted before it fills
    logic [2:0] age_ff;
    always_ff @(posedge CLK_IN or posedge RESET_IN)
        if (RESET_IN) age_ff <= 3'h0;
        else if (age_ff != 3'h7) age_ff <= age_ff + 3'h1;
    default clocking @(posedge CLK_IN); endclocking
    default disable iff (RESET_IN);
    sequence s_ctl0_wr;
        REG_WR_IN && REG_ADDR_IN == 8'h88 && REG_PAGE_IN == 8'h01;
    endsequence
    sequence s_mode0_wr;
        REG_WR_IN && REG_ADDR_IN == 8'h89 && REG_PAGE_IN == 8'h01;
    endsequence
    sequence s_mapped;
        (REG_WR_IN || REG_RD_IN) && REG_ADDR_IN[7:1] == 7'h44
            && REG_PAGE_IN >= 8'h01 && REG_PAGE_IN <= 8'h03;
    endsequence
    a_on_write: assert property (s_ctl0_wr |=> CMP_ON_OUT[0] == $past(REG_WDATA_IN[7]))
        else $error("enable bit not taken from write");
    a_hyst_write: assert property (s_ctl0_wr |=>
        {POS_HYST_SEL_OUT[1:0], NEG_HYST_SEL_OUT[1:0]} == $past(REG_WDATA_IN[3:0]))
        else $error("hysteresis select not taken from write");
    a_mode_write: assert property (s_mode0_wr |=>
        RESPONSE_MODE_SEL_OUT[1:0] == $past(REG_WDATA_IN[1:0]))
        else $error("response mode not taken from write");
    a_hit_mapped: assert property (s_mapped |=> REG_HIT_OUT)
        else $error("mapped access not acknowledged");
    a_idle_quiet: assert property (!REG_WR_IN && !REG_RD_IN |=>
        !REG_HIT_OUT && REG_RDATA_OUT == 8'h00)
        else $error("read port active without access");
    a_pin_off: assert property ((CMP_PIN_OUT & ~(CMP_ON_OUT | $past(CMP_ON_OUT))) == '0)
        else $error("pin driven while comparator off");
    a_reset_src: assert property (
        CMP_RESET_SRC_OUT == (CMP_LEVEL_OUT & $past(CMP_ON_OUT)))
        else $error("reset source differs from gated level");
    a_pin_level: assert property (
        CMP_PIN_OUT == (CMP_LEVEL_OUT & $past(CMP_ON_OUT)))
        else $error("pin path differs from gated level");
    a_irq_gate: assert property ((IRQ_REQ_OUT & ~$past(EXT_IRQ_EN_IN)) == '0)
        else $error("interrupt passed while disabled");
    a_level_sync: assert property (age_ff == 3'h7 && $stable(CMP_RAW_IN)
        && $past(CMP_RAW_IN) == $past(CMP_RAW_IN, 3) |-> CMP_LEVEL_OUT == CMP_RAW_IN)
        else $error("level does not follow settled input");
    a_ready_wait: assert property ($rose(CMP_ON_OUT[0]) |-> !CMP_READY_OUT[0] [*8])
        else $error("ready raised right after switch-on");
endmodule
`default_nettype wire

/* test/ccl_analog_model.sv */
/* behavioural model of the three analog comparator cores.
 assumes the bench commands the level of each enabled core. */
`timescale 1ns/1ps
`default_nettype none
module ccl_analog_model (
    input wire clk_in,
    input wire [2:0] on_in,
    input wire [2:0] level_in,
    output logic [2:0] raw_out = 3'h0
);
    logic [2:0] junk_ff = 3'h5;
    // a core that is shut down gives no valid level, so it wanders
    always @(negedge clk_in) begin
        junk_ff <= ~junk_ff;
        raw_out <= (on_in & level_in) | (~on_in & junk_ff);
    end
endmodule
`default_nettype wire

/* test/ccl_comparator_ctrl_test.sv */
/* self-checking bench for the comparator control block.
 assumes the design files and the analog model are compiled first. */
`timescale 1ns/1ps
`default_nettype none
module ccl_comparator_ctrl_test;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [7:0] page = 8'h00;
    logic [7:0] wdata = 8'h00;
    logic [2:0] irq_en = 3'h0;
    logic [2:0] lvl = 3'h0;
    logic [7:0] rdata;
    logic hit;
    logic hit_v;
    logic [2:0] irq, raw, on, level, pin, rsrc, ready;
    logic [5:0] phys, nhys, resp;
    int failures = 0;
    int n_compared = 0;
    always #2.5 clk = ~clk;
    ccl_comparator_ctrl #(.NUM_CMP(3)) DUT (
        .CLK_IN(clk), .RESET_IN(rst), .REG_ADDR_IN(addr), .REG_PAGE_IN(page),
        .REG_WR_IN(wr), .REG_RD_IN(rd), .REG_WDATA_IN(wdata), .REG_RDATA_OUT(rdata),
        .REG_HIT_OUT(hit), .EXT_IRQ_EN_IN(irq_en), .IRQ_REQ_OUT(irq), .CMP_RAW_IN(raw),
        .CMP_ON_OUT(on), .POS_HYST_SEL_OUT(phys), .NEG_HYST_SEL_OUT(nhys),
        .RESPONSE_MODE_SEL_OUT(resp), .CMP_LEVEL_OUT(level), .CMP_PIN_OUT(pin),
        .CMP_RESET_SRC_OUT(rsrc), .CMP_READY_OUT(ready));
    ccl_analog_model u_model (.clk_in(clk), .on_in(on), .level_in(lvl), .raw_out(raw));
    // ----------------------------------------
    // bus tasks
    // ----------------------------------------
    task check(input string name, input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp) begin
            failures++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task print_verdict;
        $display("compared %0d mismatches %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    task wr_reg(input logic [7:0] a, input logic [7:0] p, input logic [7:0] d);
        @(negedge clk);
        addr = a;
        page = p;
        wdata = d;
        wr = 1'b1;
        @(negedge clk);
        wr = 1'b0;
    endtask
    // read data stands one cycle only, so it is caught at the next negedge
    task rd_chk(input string n, input logic [7:0] a, p, m, exp);
        @(negedge clk);
        addr = a;
        page = p;
        rd = 1'b1;
        @(negedge clk);
        hit_v = hit;
        rd = 1'b0;
        check(n, rdata & m, exp);
    endtask
    task t_reset;
        for (int p = 1; p <= 3; p++) begin
            rd_chk("ctrl", 8'h88, p[7:0], 8'hbf, 8'h00);
            rd_chk("mode", 8'h89, p[7:0], 8'hff, 8'h02);
        end
        check("resp", {2'h0, resp}, 8'h2a);
    endtask
    task t_unmapped;
        rd_chk("unmapped", 8'h88, 8'h04, 8'hff, 8'h00);
        check("hit", {7'h0, hit_v}, 8'h00);
        wr_reg(8'h88, 8'h00, 8'hff);
        check("on", {5'h0, on}, 8'h00);
    endtask
    task t_config;
        for (int c = 0; c < 4; c++) begin
            wr_reg(8'h88, 8'h01, {4'h0, c[1:0], c[1:0]});
            check("hyst", {phys[1:0], nhys[1:0]}, {4'h0, c[1:0], c[1:0]});
            wr_reg(8'h89, 8'h01, c[7:0]);
            check("resp", {6'h0, resp[1:0]}, c[7:0]);
        end
        wr_reg(8'h88, 8'h02, 8'h80);
        check("on", {5'h0, on}, 8'h02);
        wr_reg(8'h88, 8'h02, 8'h00);
        wr_reg(8'h89, 8'h03, 8'hff);
        rd_chk("mode", 8'h89, 8'h03, 8'hff, 8'h33);
    endtask
    task t_edges;
        wr_reg(8'h88, 8'h01, 8'h80);
        // output is unreliable until the power-up time has passed
        repeat (2100) @(negedge clk);
        check("ready", {7'h0, ready[0]}, 8'h01);
        irq_en = 3'h1;
        wr_reg(8'h89, 8'h01, 8'h30);
        wr_reg(8'h88, 8'h01, 8'h80);
        lvl = 3'h1;
        repeat (8) @(negedge clk);
        rd_chk("rise", 8'h88, 8'h01, 8'hff, 8'he0);
        check("irq", {5'h0, irq}, 8'h01);
        check("pin", {5'h0, pin}, 8'h01);
        check("hit", {7'h0, hit_v}, 8'h01);
        check("level", {7'h0, level[0]}, 8'h01);
        check("rsrc", {5'h0, rsrc}, 8'h01);
        irq_en = 3'h0;
        repeat (2) @(negedge clk);
        check("irq", {5'h0, irq}, 8'h00);
        irq_en = 3'h1;
        wr_reg(8'h88, 8'h01, 8'h80);
        rd_chk("clear", 8'h88, 8'h01, 8'hff, 8'hc0);
        lvl = 3'h0;
        repeat (8) @(negedge clk);
        rd_chk("fall", 8'h88, 8'h01, 8'hff, 8'h90);
        check("level", {7'h0, level[0]}, 8'h00);
        check("rsrc", {5'h0, rsrc}, 8'h00);
        check("irq", {5'h0, irq}, 8'h01);
        wr_reg(8'h89, 8'h01, 8'h20);
        repeat (2) @(negedge clk);
        check("irq", {5'h0, irq}, 8'h00);
        wr_reg(8'h88, 8'h01, 8'h00);
        repeat (8) @(negedge clk);
        check("pin", {5'h0, pin}, 8'h00);
        rd_chk("flags", 8'h88, 8'h01, 8'hb0, 8'h00);
    endtask
    initial begin
        repeat (20) @(posedge clk);
        @(negedge clk);
        rst = 1'b0;
        t_reset;
        t_unmapped;
        t_config;
        t_edges;
        print_verdict;
    end
    initial begin
        #100000;
        failures++;
        print_verdict;
    end
endmodule
bind ccl_comparator_ctrl ccl_chk #(.NUM_CMP(NUM_CMP)) u_chk (
    .CLK_IN(CLK_IN), .RESET_IN(RESET_IN), .REG_ADDR_IN(REG_ADDR_IN), .REG_PAGE_IN(REG_PAGE_IN),
    .REG_WR_IN(REG_WR_IN), .REG_RD_IN(REG_RD_IN), .REG_WDATA_IN(REG_WDATA_IN),
    .REG_RDATA_OUT(REG_RDATA_OUT), .REG_HIT_OUT(REG_HIT_OUT), .EXT_IRQ_EN_IN(EXT_IRQ_EN_IN),
    .IRQ_REQ_OUT(IRQ_REQ_OUT), .CMP_RAW_IN(CMP_RAW_IN), .CMP_ON_OUT(CMP_ON_OUT),
    .POS_HYST_SEL_OUT(POS_HYST_SEL_OUT), .NEG_HYST_SEL_OUT(NEG_HYST_SEL_OUT),
    .RESPONSE_MODE_SEL_OUT(RESPONSE_MODE_SEL_OUT), .CMP_LEVEL_OUT(CMP_LEVEL_OUT),
    .CMP_PIN_OUT(CMP_PIN_OUT), .CMP_RESET_SRC_OUT(CMP_RESET_SRC_OUT),
    .CMP_READY_OUT(CMP_READY_OUT));
`default_nettype wire
